// ===== bench/host_rom_partner.sv
// model of the boot host and the boot rom beyond the sequencer
`timescale 1ns/100ps
`default_nettype none

module host_rom_partner (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // scenario controls
  input wire logic hostGo,
  input wire logic slow,
  input wire logic romOn,
  // host port control bit
  output logic hostToCpuInterruptSet,
  // boot rom read
  input wire logic romRdReq,
  input wire logic [31:0] romRdAddr,
  output logic romRdValid,
  output logic [7:0] romRdData
);
  logic [2:0] waitCnt; // cycles left before the host sets the bit
  logic phase; // a slow rom answers every other cycle
  logic [7:0] lastData; // last byte handed over

  ////////////////////////////////////////////////////////////////////////////
  // host loads memory, then sets the bit once after a short or long delay
  always_ff @(posedge clk) begin
    if (rst) begin
      waitCnt <= 3'h0;
      hostToCpuInterruptSet <= 1'b0;
      phase <= 1'b0;
      lastData <= 8'h00;
    end else begin
      hostToCpuInterruptSet <= (waitCnt == 3'h1);
      if (hostGo) begin
        waitCnt <= slow ? 3'h5 : 3'h1;
      end else if (waitCnt != 3'h0) begin
        waitCnt <= waitCnt - 3'h1;
      end
      phase <= ~phase;
      if (romRdReq && romRdValid) begin
        lastData <= romRdData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte equals the low address byte; a released bus shows the inverse of the last byte,
  // so a design that samples outside a valid cycle picks up wrong data
  assign romRdValid = romOn && romRdReq && (!slow || phase);
  assign romRdData = romRdValid ? romRdAddr[7:0] : ~lastData;
endmodule // host_rom_partner
`default_nettype wire

// ===== bench/reset_and_boot_sequencer_bench.sv
// self-checking testbench of the reset and boot sequencer
`timescale 1ns/100ps
`default_nettype none

module reset_and_boot_sequencer_bench;
  logic clk, rst, ce, resetPinN, trstPinIn, trstPinDriven, pciSelPin;
  logic emulationModePinHi, emulationModePinLo, bigEndianPin, cpuIntClear;
  logic hostGo, slow, romOn, hostToCpuInterruptSet, hostToCpuInterruptBit;
  logic hostMemAccessEn, hostPortSel, hostPciSel, hostToCpuInterruptCpu;
  logic coreResetN, periphResetN, cpuStall, cpuRun, testLogicReset;
  logic idcodeVariantValid, emuModeValid, romRdReq, romDefaultTiming;
  logic romRdValid, memWrEn;
  logic [1:0] bootModePin, emuModeLatched;
  logic [7:0] romRdData;
  logic [31:0] cpuBootAddr, romRdAddr, memWrAddr, memWrData;
  int failCount = 0, compares = 0, cycles = 0, wrCount = 0, cpuPulses = 0;

  // one row: boot code and select, then the expected levels after release
  typedef struct packed {
    logic [1:0] code; logic pci; logic stall; logic run; logic hostEn;
    logic req;
  } row_t;
  row_t rows [6] = '{'{2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
    '{2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
    '{2'h1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0},
    '{2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
    '{2'h3, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
    '{2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0}};

  reset_and_boot_sequencer i_dut (.clk, .rst, .ce, .resetPinN,
    .trstPinIn, .trstPinDriven, .emulationModePinHi, .emulationModePinLo,
    .bootModePin, .pciSelPin, .bigEndianPin, .hostToCpuInterruptSet,
    .hostToCpuInterruptBit, .hostMemAccessEn, .hostPortSel, .hostPciSel,
    .cpuIntClear, .hostToCpuInterruptCpu, .coreResetN, .periphResetN,
    .cpuStall, .cpuRun, .cpuBootAddr, .testLogicReset, .idcodeVariantValid,
    .emuModeLatched, .emuModeValid, .romRdReq, .romRdAddr, .romDefaultTiming,
    .romRdValid, .romRdData, .memWrEn, .memWrAddr, .memWrData);

  host_rom_partner i_host (.clk, .rst, .hostGo, .slow, .romOn,
    .hostToCpuInterruptSet, .romRdReq, .romRdAddr, .romRdValid, .romRdData);

  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // one compare for every kind of result, widened to a word
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task stopTest;
    $display("compares=%0d mismatches=%0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // packed word i of the rom image, whose bytes equal their address
  function logic [31:0] expWord(input int i);
    logic [31:0] w;
    for (int j = 0; j < 4; j++) begin
      if (bigEndianPin) w[8*(3-j) +: 8] = 8'(4 * i + j);
      else w[8*j +: 8] = 8'(4 * i + j);
    end
    return w;
  endfunction

  // device reset with boot pins set, checked in hold, then released
  task boot(input logic [1:0] code, input logic pci, input logic be,
      input logic rom);
    @(posedge clk);
    resetPinN <= 1'b0;
    bootModePin <= code;
    pciSelPin <= pci;
    bigEndianPin <= be;
    romOn <= rom;
    cyc(5);
    @(negedge clk);
    chk(coreResetN, 1'b0);
    chk(idcodeVariantValid, 1'b0);
    @(posedge clk);
    resetPinN <= 1'b1;
    wrCount = 0;
    cyc(7);
    @(negedge clk);
    chk(coreResetN, 1'b1);
  endtask

  // host asks the partner to set the bit, then time to act on it
  task goHost;
    @(posedge clk);
    hostGo <= 1'b1;
    @(posedge clk);
    hostGo <= 1'b0;
    cyc(8);
    @(negedge clk);
  endtask

  // bounded wait for the cpu to run; a miss shows in the compare
  task waitRun(input int lim);
    int k;
    k = 0;
    while (cpuRun !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    @(negedge clk);
    chk(cpuRun, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hang guard, forwarded-interrupt count and copied-word check;
  // sampled on the falling edge, away from the edge that launches them
  always @(negedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 9000) begin
      failCount++;
      stopTest();
    end
    if (hostToCpuInterruptCpu === 1'b1) cpuPulses++;
    if (memWrEn === 1'b1) begin
      chk(memWrAddr, wrCount * 4);
      chk(memWrData, expWord(wrCount));
      wrCount++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: both resets held at power-up, test reset undriven
  initial begin
    rst = 1'b1;
    resetPinN = 1'b0;
    trstPinIn = 1'b0;
    trstPinDriven = 1'b0;
    {emulationModePinHi, emulationModePinLo} = 2'h0;
    {bootModePin, pciSelPin, bigEndianPin} = 4'h0;
    {cpuIntClear, hostGo, slow, romOn} = 4'h0;
    ce = 1'b1;
    cyc(6);
    rst <= 1'b0;
    @(negedge clk);
    chk(testLogicReset, 1'b1);
    foreach (rows[i]) begin
      boot(rows[i].code, rows[i].pci, 1'b0, 1'b0);
      chk(cpuStall, rows[i].stall);
      chk(cpuRun, rows[i].run);
      chk(hostMemAccessEn, rows[i].hostEn);
      chk(romRdReq, rows[i].req);
      chk(romDefaultTiming, rows[i].req);
      chk(periphResetN, 1'b1);
      chk(cpuBootAddr, 32'h0);
      chk(idcodeVariantValid, 1'b1);
      chk(testLogicReset, 1'b1);
      if (rows[i].hostEn) begin
        chk(hostPciSel, rows[i].pci);
        chk(hostPortSel, !rows[i].pci);
      end
    end
    // host boot with a slow host, then the bit handshake with the cpu
    slow <= 1'b1;
    boot(2'h1, 1'b1, 1'b0, 1'b0);
    cpuPulses = 0;
    goHost();
    chk(cpuRun, 1'b1);
    chk(cpuStall, 1'b0);
    chk(hostToCpuInterruptBit, 1'b1);
    chk(cpuPulses, 0);
    goHost();
    chk(cpuPulses, 0);
    @(posedge clk);
    cpuIntClear <= 1'b1;
    @(posedge clk);
    cpuIntClear <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk(hostToCpuInterruptBit, 1'b0);
    goHost();
    chk(cpuPulses, 1);
    // rom boot with the rom silent: the host bit must not release the cpu
    boot(2'h2, 1'b0, 1'b0, 1'b0);
    goHost();
    chk(cpuRun, 1'b0);
    chk(cpuStall, 1'b1);
    // full copies: slow rom little endian, fast rom big endian
    for (int e = 0; e < 2; e++) begin
      slow <= !e[0];
      boot(2'h2, 1'b0, e[0], 1'b1);
      waitRun(3000);
      chk(wrCount, 256);
      chk(cpuStall, 1'b0);
    end
    // boot pins move after release: the flow must not change
    boot(2'h0, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    bootModePin <= 2'h1;
    cyc(6);
    @(negedge clk);
    chk(cpuRun, 1'b1);
    chk(hostMemAccessEn, 1'b0);
    // test reset rise in device reset is ignored, after release latches
    @(posedge clk);
    resetPinN <= 1'b0;
    trstPinDriven <= 1'b1;
    {emulationModePinHi, emulationModePinLo} <= 2'h2;
    cyc(3);
    trstPinIn <= 1'b1;
    cyc(6);
    @(negedge clk);
    chk(emuModeValid, 1'b0);
    chk(testLogicReset, 1'b0);
    @(posedge clk);
    trstPinIn <= 1'b0;
    resetPinN <= 1'b1;
    cyc(8);
    trstPinIn <= 1'b1;
    cyc(6);
    @(negedge clk);
    chk(emuModeValid, 1'b1);
    chk(emuModeLatched, 2'h2);
    // enable low freezes the host stall: the host bit is not taken
    @(posedge clk);
    ce <= 1'b0;
    goHost();
    chk(cpuStall, 1'b1);
    chk(hostToCpuInterruptBit, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    goHost();
    chk(cpuRun, 1'b1);
    stopTest();
  end
endmodule // reset_and_boot_sequencer_bench
`default_nettype wire

// ===== rtl/boot_copy_packer.sv
// packs rom bytes into 32-bit words for the boot copy
`timescale 1ns/100ps
`default_nettype none
`include "reset_boot_params.svh"

module boot_copy_packer
  import reset_boot_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // byte side
  input wire logic clear,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic bigEndian,
  // word side
  output logic wordValid,
  output logic [31:0] wordData
);

  pack_reg_t r; // registered state
  pack_reg_t n; // next state

  ////////////////////////////////////////////////////////////////////////////
  // next state: lane order follows the endian choice
  always_comb begin
    logic [31:0] tmp;
    logic [1:0] pos;
    tmp = r.acc;
    pos = bigEndian ? ~r.lane : r.lane;
    n = r;
    n.wordValid = 1'b0;
    if (clear) begin
      // a new copy starts on lane zero
      n.lane = 2'h0;
    end else if (byteValid) begin
      tmp[{pos, 3'h0} +: 8] = byteData; // [R14]
      n.acc = tmp;
      if (r.lane == `RB_LAST_LANE) begin
        // fourth byte closes the word
        n.word = tmp; // [R14]
        n.wordValid = 1'b1;
        n.lane = 2'h0;
      end else begin
        n.lane = r.lane + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign wordValid = r.wordValid;
  assign wordData = r.word;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_word_after_fourth;
    @(posedge clk) disable iff (rst || !ce)
      (byteValid && !clear && r.lane == `RB_LAST_LANE) |=> wordValid;
  endproperty
  a_word_after_fourth: // [R14]
    assert property (p_word_after_fourth)
    else $error("no word after fourth byte");

  property p_little_lane0;
    @(posedge clk) disable iff (rst || !ce)
      (byteValid && !clear && r.lane == 2'h0 && !bigEndian)
      |=> (r.acc[7:0] == $past(byteData));
  endproperty
  a_little_lane0: // [R14]
    assert property (p_little_lane0)
    else $error("little endian first byte misplaced");

endmodule // boot_copy_packer
`default_nettype wire

// ===== rtl/reset_and_boot_sequencer.sv
// reset and boot sequencer: device reset, test reset, boot flows
// How it works
// R1 - low device reset holds everything in reset
// R2 - system asserts both resets at power-up
// R3 - device reset release alone boots normally
// R4 - idcode variant valid only after reset release
// R5 - undriven test reset pin pulls low
// R6 - test reset rise latches emulation pins; a rise while device reset is low is ignored
// R7 - host boot: cpu stalled, rest released
// R8 - host port or pci chosen by select
// R9 - host sets interrupt bit to finish boot
// R10 - ending interrupt not passed to cpu
// R11 - host may read and write memory
// R12 - bit set blocks new interrupts until cleared
// R13 - rom boot copies 1k bytes, cpu stalled
// R14 - bytes packed to words by endian
// R15 - copy end releases cpu at zero
// R16 - no boot runs from zero at once
// R17 - boot config sampled at reset release
`timescale 1ns/100ps
`default_nettype none
`include "reset_boot_params.svh"

module reset_and_boot_sequencer
  import reset_boot_pkg::*;
#(
  parameter logic HAS_PCI = 1'b1, // part carries a pci host interface
  parameter logic [31:0] BOOT_ROM_BASE = 32'h00000000 // boot rom space
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // device pins
  input wire logic resetPinN,
  input wire logic trstPinIn,
  input wire logic trstPinDriven,
  input wire logic emulationModePinHi,
  input wire logic emulationModePinLo,
  input wire logic [1:0] bootModePin,
  input wire logic pciSelPin,
  input wire logic bigEndianPin,
  // host port control bit
  input wire logic hostToCpuInterruptSet,
  output logic hostToCpuInterruptBit,
  output logic hostMemAccessEn,
  output logic hostPortSel,
  output logic hostPciSel,
  // cpu side
  input wire logic cpuIntClear,
  output logic hostToCpuInterruptCpu,
  output logic coreResetN,
  output logic periphResetN,
  output logic cpuStall,
  output logic cpuRun,
  output logic [31:0] cpuBootAddr,
  // test logic
  output logic testLogicReset,
  output logic idcodeVariantValid,
  output logic [1:0] emuModeLatched,
  output logic emuModeValid,
  // boot rom read
  output logic romRdReq,
  output logic [31:0] romRdAddr,
  output logic romDefaultTiming,
  input wire logic romRdValid,
  input wire logic [7:0] romRdData,
  // memory write of copied words
  output logic memWrEn,
  output logic [31:0] memWrAddr,
  output logic [31:0] memWrData
);

  seq_reg_t r; // registered state
  seq_reg_t n; // next state
  logic trstInternalPulldown; // pin level with the pull-down applied
  logic release_; // device reset rising edge, after sync
  logic pkClear; // restart packer lanes
  logic pkByteValid; // byte accepted from the rom
  logic pkWordValid; // packed word ready
  logic [31:0] pkWord; // packed word

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // map pin code to a boot flow; reserved code falls back to no boot
  function automatic boot_mode_t decodeBootMode(input logic [1:0] code);
    case (code)
      `RB_CODE_HOST: decodeBootMode = BOOT_HOST;
      `RB_CODE_ROM: decodeBootMode = BOOT_ROM;
      default: decodeBootMode = BOOT_NONE;
    endcase
  endfunction

  // an undriven pin reads low, so test logic starts in reset
  assign trstInternalPulldown = trstPinDriven ? trstPinIn : 1'b0; // [R5]

  assign release_ = r.rstPinS2 && !r.rstPinPrev;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = r;
    // two-stage synchronisers on every pin
    n.rstPinS1 = resetPinN;
    n.rstPinS2 = r.rstPinS1;
    n.rstPinPrev = r.rstPinS2;
    n.trstS1 = trstInternalPulldown;
    n.trstS2 = r.trstS1;
    n.trstPrev = r.trstS2;
    n.emuS1 = {emulationModePinHi, emulationModePinLo};
    n.emuS2 = r.emuS1;
    n.cfgS1 = {bigEndianPin, pciSelPin, bootModePin};
    n.cfgS2 = r.cfgS1;
    n.cpuHostInt = 1'b0;

    // emulation pins caught on a test reset rise once reset is released
    if (r.trstS2 && !r.trstPrev && r.rstPinS2) begin
      n.emuLatched = r.emuS2; // [R6]
      n.emuValid = 1'b1;
    end

    // interrupt bit: a set in the cycle of a clear wins
    if (cpuIntClear) begin
      n.hostIntBit = 1'b0; // [R12]
    end
    if (hostToCpuInterruptSet) begin
      n.hostIntBit = 1'b1;
      // forwarded only while running and not blocked by a pending bit
      if (r.state == ST_RUN && (!r.hostIntBit || cpuIntClear)) begin
        n.cpuHostInt = 1'b1; // [R12]
      end
    end

    case (r.state)
      ST_HOLD: begin
        n.hostIntBit = 1'b0;
        n.byteCnt = '0;
        n.wordCnt = '0;
        // trst plays no part here: the device reset alone starts boot
        if (release_) begin // [R3]
          // boot configuration frozen until the next reset
          n.bootMode = decodeBootMode(r.cfgS2[1:0]); // [R17]
          n.pciSel = r.cfgS2[2]; // [R17]
          n.bigEndian = r.cfgS2[3]; // [R17]
          n.romAddr = BOOT_ROM_BASE; // [R13]
          case (decodeBootMode(r.cfgS2[1:0]))
            BOOT_HOST: n.state = ST_HOST_STALL; // [R7]
            BOOT_ROM: n.state = ST_COPY; // [R13]
            default: n.state = ST_RUN; // [R16]
          endcase
        end
      end
      ST_HOST_STALL: begin
        // the bit ends the stall but never reaches the cpu as an interrupt
        if (hostToCpuInterruptSet && r.bootMode == BOOT_HOST) begin
          n.state = ST_RUN; // [R10]
        end
      end
      ST_COPY: begin
        // one rom byte per valid, up to the fixed copy size
        if (romRdValid && r.byteCnt < `RB_COPY_BYTES) begin
          n.byteCnt = r.byteCnt + 11'h1; // [R13]
          n.romAddr = r.romAddr + 32'h1;
        end
        // single block: last word written ends the stall
        if (pkWordValid) begin
          n.wordCnt = r.wordCnt + 9'h1;
          if (r.wordCnt == `RB_LAST_WORD) begin
            n.state = ST_RUN; // [R15]
          end
        end
      end
      ST_RUN: begin
        // running; only a device reset leaves this state
      end
      default: begin
        n.state = ST_HOLD;
      end
    endcase

    // device reset low overrides everything
    if (!r.rstPinS2) begin
      n.state = ST_HOLD; // [R1]
      n.hostIntBit = 1'b0;
      n.cpuHostInt = 1'b0;
      n.emuValid = 1'b0;
      n.emuLatched = `RB_EMU_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; rst is the power-on clear of the sequencer itself
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot copy packer
  assign pkClear = release_;
  assign pkByteValid = romRdReq && romRdValid;

  boot_copy_packer u_packer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clear(pkClear),
    .byteValid(pkByteValid),
    .byteData(romRdData),
    .bigEndian(r.bigEndian),
    .wordValid(pkWordValid),
    .wordData(pkWord)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all decoded from registered state
  assign coreResetN = (r.state != ST_HOLD); // [R1]
  assign periphResetN = (r.state != ST_HOLD); // [R7]
  assign cpuStall = (r.state == ST_HOST_STALL) || (r.state == ST_COPY);
  assign cpuRun = (r.state == ST_RUN); // [R16]
  assign cpuBootAddr = `RB_ENTRY_ADDR; // [R15]
  // host reaches all memory whenever host boot was chosen
  assign hostMemAccessEn = (r.state != ST_HOLD) &&
                           (r.bootMode == BOOT_HOST); // [R11]
  // parts without pci always use the host port
  assign hostPciSel = hostMemAccessEn && HAS_PCI && r.pciSel; // [R8]
  assign hostPortSel = hostMemAccessEn && !(HAS_PCI && r.pciSel); // [R8]
  assign hostToCpuInterruptBit = r.hostIntBit;
  assign hostToCpuInterruptCpu = r.cpuHostInt;
  // test reset is active low on the pin, shown here active high
  assign testLogicReset = !r.trstS2;
  assign idcodeVariantValid = r.rstPinS2 && (r.state != ST_HOLD); // [R4]
  assign emuModeLatched = r.emuLatched;
  assign emuModeValid = r.emuValid;
  // rom request holds through the copy until all copy bytes have arrived
  assign romRdReq = (r.state == ST_COPY) && (r.byteCnt < `RB_COPY_BYTES);
  assign romRdAddr = r.romAddr;
  assign romDefaultTiming = (r.state == ST_COPY); // [R13]
  assign memWrEn = pkWordValid;
  assign memWrAddr = {21'h0, r.wordCnt, 2'h0};
  assign memWrData = pkWord;

  ////////////////////////////////////////////////////////////////////////////
  // checks, all on clk and idle while rst is high or ce is low
  default clocking chkClk @(posedge clk);
  endclocking
  default disable iff (rst || !ce);
  property p_hold_on_reset;
    !r.rstPinS2 |=> (!coreResetN && !periphResetN && !cpuRun);
  endproperty
  a_hold_on_reset: assert property (p_hold_on_reset) // [R1]
    else $error("device not held while reset low");
  property p_boot_without_trst;
    (release_ && testLogicReset) |=> (periphResetN && coreResetN);
  endproperty
  a_boot_without_trst: assert property (p_boot_without_trst) // [R3]
    else $error("boot blocked by test reset");
  // the variant flag drops in the same cycle as the synced reset falls
  property p_variant_needs_release;
    !r.rstPinS2 |=> !idcodeVariantValid;
  endproperty
  a_variant_needs_release: assert property (p_variant_needs_release) // [R4]
    else $error("idcode variant valid in reset");
  property p_pulldown;
    !trstPinDriven |-> ##2 testLogicReset;
  endproperty
  a_pulldown: assert property (p_pulldown) // [R5]
    else $error("undriven test reset not asserted");
  property p_emu_latch;
    (r.trstS2 && !r.trstPrev && r.rstPinS2)
    |=> (emuModeValid && emuModeLatched == $past(r.emuS2));
  endproperty
  a_emu_latch: assert property (p_emu_latch) // [R6]
    else $error("emulation pins not latched on test reset rise");
  property p_host_stall;
    (release_ && decodeBootMode(r.cfgS2[1:0]) == BOOT_HOST)
    |=> (cpuStall && periphResetN && hostMemAccessEn) [*2];
  endproperty
  a_host_stall: assert property (p_host_stall) // [R7]
    else $error("host boot does not stall cpu");
  property p_one_host_path;
    hostMemAccessEn |-> (hostPortSel ^ hostPciSel);
  endproperty
  a_one_host_path: assert property (p_one_host_path) // [R8]
    else $error("host boot path not unique");
  property p_stall_end_silent;
    (r.state == ST_HOST_STALL && hostToCpuInterruptSet && r.rstPinS2)
    |=> (cpuRun && !hostToCpuInterruptCpu && hostToCpuInterruptBit);
  endproperty
  a_stall_end_silent: assert property (p_stall_end_silent) // [R10]
    else $error("stall end passed to cpu or missed");
  property p_blocked_while_set;
    (hostToCpuInterruptBit && !cpuIntClear && hostToCpuInterruptSet)
    |=> !hostToCpuInterruptCpu;
  endproperty
  a_blocked_while_set: assert property (p_blocked_while_set) // [R12]
    else $error("interrupt passed while bit pending");
  property p_copy_end;
    (r.state == ST_COPY && memWrEn && memWrAddr[10:2] == `RB_LAST_WORD
     && r.rstPinS2) |=> (cpuRun && !cpuStall);
  endproperty
  a_copy_end: assert property (p_copy_end) // [R15]
    else $error("cpu not released after last copy word");
  property p_copy_stalls;
    romRdReq |-> (cpuStall && romDefaultTiming);
  endproperty
  a_copy_stalls: assert property (p_copy_stalls) // [R13]
    else $error("cpu not stalled during copy");
  property p_no_boot_direct;
    (release_ && decodeBootMode(r.cfgS2[1:0]) == BOOT_NONE)
    |=> (cpuRun && !cpuStall);
  endproperty
  a_no_boot_direct: assert property (p_no_boot_direct) // [R16]
    else $error("no boot did not run at once");
  property p_cfg_frozen;
    !release_ |=> $stable(r.bootMode) && $stable(r.pciSel);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) // [R17]
    else $error("boot configuration changed outside release");

endmodule // reset_and_boot_sequencer
`default_nettype wire

// ===== rtl/reset_boot_params.svh
// constants for the reset and boot sequencer
`ifndef RESET_BOOT_PARAMS_SVH
`define RESET_BOOT_PARAMS_SVH

// boot mode pin codes
`define RB_CODE_NONE 2'h0
`define RB_CODE_HOST 2'h1
`define RB_CODE_ROM 2'h2

// boot copy size: bytes, and index of the last word
`define RB_COPY_BYTES 11'h400
`define RB_LAST_WORD 9'h0ff

// entry address of the cpu after any boot flow
`define RB_ENTRY_ADDR 32'h00000000

// packer lane of the last byte of a word
`define RB_LAST_LANE 2'h3

// reset values
`define RB_EMU_RST 2'h0
`define RB_CFG_RST 4'h0

`endif

// ===== rtl/reset_boot_pkg.sv
// types of the reset and boot sequencer
package reset_boot_pkg;

  // boot flow selected at reset release
  typedef enum logic [1:0] {BOOT_NONE, BOOT_HOST, BOOT_ROM} boot_mode_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_HOLD, ST_HOST_STALL, ST_COPY, ST_RUN
  } seq_state_t;

  // whole state of the sequencer
  typedef struct packed {
    logic rstPinS1;
    logic rstPinS2;
    logic rstPinPrev;
    logic trstS1;
    logic trstS2;
    logic trstPrev;
    logic [1:0] emuS1;
    logic [1:0] emuS2;
    logic [3:0] cfgS1;
    logic [3:0] cfgS2;
    seq_state_t state;
    boot_mode_t bootMode;
    logic pciSel;
    logic bigEndian;
    logic hostIntBit;
    logic cpuHostInt;
    logic [1:0] emuLatched;
    logic emuValid;
    logic [10:0] byteCnt;
    logic [8:0] wordCnt;
    logic [31:0] romAddr;
  } seq_reg_t;

  // whole state of the byte packer
  typedef struct packed {
    logic [1:0] lane;
    logic [31:0] acc;
    logic [31:0] word;
    logic wordValid;
  } pack_reg_t;

endpackage
